// ---- verilog/swr_supervisor.sv ----
// watchdog and reset sequencer of a dual-supply processor supervisor
// assumes supply comparators arrive as logic levels, high meaning good,
// and a watchdog pin resolved outside from the drive and enable below
//
// Function
// - if the kick input shows no edge for a watchdog period, reset is
//     asserted for the full hold time.
// - any rising or falling kick edge, or reset, clears the watchdog timer.
// - a kick pulse as narrow as 50 ns counts as a valid toggle.
// - while reset is asserted the watchdog timer stays at zero.
// - the watchdog timer starts from zero as soon as reset is released.
// - the weak internal driver holds the kick pin low for 7/8 of the
//     period and high for the last 1/8.
// - a floating kick pin therefore toggles about every 1.4 s and the
//     watchdog never expires.
// - a bouncing switch on the manual reset input gives a clean reset.
// - reset stays asserted for at least 140 ms after all causes end.
// - reset is asserted while any supply or the monitor input is low.
// - a low manual reset asserts reset until the hold time after release.
// - reset is shown both as an active-low and an active-high output.
`include "swr_consts.svh"

module swr_supervisor
  import swr_pkg::*;
#(
  parameter int WDOG_CYCLES  = `SWR_WDOG_CYCLES,
  parameter int HOLD_CYCLES  = `SWR_RESET_HOLD_CYCLES,
  parameter int DEBNC_CYCLES = `SWR_MR_DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // supply comparators, high while above threshold
  input  wire logic i_supply_ok,
  input  wire logic i_supply2_ok,
  input  wire logic i_adjustable_monitor_input,
  // manual reset, active low
  input  wire logic i_manual_reset_n,
  // watchdog kick pin, three signals
  input  wire logic i_watchdog_kick_input,
  output logic      o_watchdog_kick_out,
  output logic      o_watchdog_kick_oe,
  // reset outputs, both polarities
  output logic      o_reset_n,
  output logic      o_reset
);

  // ----------------------------------------------------------------------
  // derived widths and terminal counts
  // ----------------------------------------------------------------------
  localparam int WW = $clog2(WDOG_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_CYCLES - 1);
  localparam logic [WW-1:0] KICK_HIGH_AT =
    WW'((WDOG_CYCLES / `SWR_KICK_LOW_DEN) * `SWR_KICK_LOW_NUM);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  swr_state_type state_reg;
  swr_state_type state_next;
  logic [WW-1:0] wdt_cnt_reg;
  logic [WW-1:0] wdt_cnt_next;
  logic [HW-1:0] hold_cnt_reg;
  logic [HW-1:0] hold_cnt_next;
  logic          reset_reg;
  logic          reset_n_reg;
  logic          kick_drive_reg;
  logic          kick_oe_reg;
  logic          kick_prev_reg;
  logic          kick_level;
  logic          mr_level;
  logic          kick_edge;
  logic          cause;
  logic          wdt_expire;
  logic          hold_done;

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  // kick needs no filter: a single-cycle pulse must still register
  swr_sync_filter #(
    .FILTER_CYCLES (1),
    .INIT_LEVEL    (`SWR_KICK_RESET_LEVEL)
  ) u_kick_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_raw     (i_watchdog_kick_input),
    .o_level   (kick_level)
  );

  // manual reset gets a debounce window much longer than switch bounce
  swr_sync_filter #(
    .FILTER_CYCLES (DEBNC_CYCLES),
    .INIT_LEVEL    (`SWR_MR_RESET_LEVEL)
  ) u_mr_filter (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_raw     (i_manual_reset_n),
    .o_level   (mr_level)
  );

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // both edge directions clear the timer
  assign kick_edge = kick_level != kick_prev_reg;
  // supply comparators are taken as already clean levels
  assign cause = !i_supply_ok || !i_supply2_ok ||
                 !i_adjustable_monitor_input || !mr_level;
  assign wdt_expire = !reset_reg && !kick_edge &&
                      (wdt_cnt_reg == WDOG_LAST);
  assign hold_done  = hold_cnt_reg == HOLD_LAST;

  // watchdog timer: cleared by reset or edge, else counts
  assign wdt_cnt_next = (reset_reg || kick_edge) ? '0 :
                        wdt_cnt_reg + 1'b1;
  assign hold_cnt_next = (state_reg == SWR_ST_HOLD) ?
                         hold_cnt_reg + 1'b1 : '0;

  // ----------------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------------
  // a new cause always restarts the hold time from the top
  always_comb begin
    case (state_reg)
      SWR_ST_CAUSE: begin
        state_next = cause ? SWR_ST_CAUSE : SWR_ST_HOLD;
      end
      SWR_ST_HOLD: begin
        if (cause) begin
          state_next = SWR_ST_CAUSE;
        end else if (hold_done) begin
          state_next = SWR_ST_RUN;
        end else begin
          state_next = SWR_ST_HOLD;
        end
      end
      SWR_ST_RUN: begin
        if (cause) begin
          state_next = SWR_ST_CAUSE;
        end else if (wdt_expire) begin
          state_next = SWR_ST_HOLD;
        end else begin
          state_next = SWR_ST_RUN;
        end
      end
      default: begin
        state_next = SWR_ST_CAUSE;
      end
    endcase
  end

  // state and counters; power-up starts in reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg     <= SWR_ST_CAUSE;
      hold_cnt_reg  <= '0;
      wdt_cnt_reg   <= '0;
      kick_prev_reg <= `SWR_KICK_RESET_LEVEL;
    end else begin
      state_reg     <= state_next;
      hold_cnt_reg  <= hold_cnt_next;
      wdt_cnt_reg   <= wdt_cnt_next;
      kick_prev_reg <= kick_level;
    end
  end

  // ----------------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------------
  // weak driver high only in the last 1/8, so an open pin toggles at 7/8
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      reset_reg      <= 1'b1;
      reset_n_reg    <= 1'b0;
      kick_drive_reg <= 1'b0;
      kick_oe_reg    <= 1'b0;
    end else begin
      reset_reg      <= state_next != SWR_ST_RUN;
      reset_n_reg    <= state_next == SWR_ST_RUN;
      kick_drive_reg <= wdt_cnt_next >= KICK_HIGH_AT;
      kick_oe_reg    <= 1'b1;
    end
  end

  assign o_reset             = reset_reg;
  assign o_reset_n           = reset_n_reg;
  assign o_watchdog_kick_out = kick_drive_reg;
  assign o_watchdog_kick_oe  = kick_oe_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  property p_expire_reset;
    wdt_expire && !cause |=> reset_reg && state_reg == SWR_ST_HOLD
      && hold_cnt_reg == '0;
  endproperty
  a_expire_reset: assert property (p_expire_reset)
    else $error("watchdog expiry did not start the hold time");

  property p_edge_clears;
    kick_edge && !reset_reg |=> wdt_cnt_reg == '0;
  endproperty
  a_edge_clears: assert property (p_edge_clears)
    else $error("kick edge did not clear the watchdog timer");

  property p_narrow_pulse;
    $changed(i_watchdog_kick_input) |-> ##[3:5] wdt_cnt_reg == '0;
  endproperty
  a_narrow_pulse: assert property (p_narrow_pulse)
    else $error("narrow kick pulse missed");

  property p_held_in_reset;
    reset_reg |=> wdt_cnt_reg == '0;
  endproperty
  a_held_in_reset: assert property (p_held_in_reset)
    else $error("watchdog timer moved during reset");

  property p_start_on_release;
    $fell(reset_reg) && !kick_edge |-> wdt_cnt_reg == '0 ##1
      wdt_cnt_reg == WW'(1);
  endproperty
  a_start_on_release: assert property (p_start_on_release)
    else $error("watchdog timer did not start from zero");

  property p_drive_high_at;
    $rose(kick_drive_reg) |-> wdt_cnt_reg == KICK_HIGH_AT;
  endproperty
  a_drive_high_at: assert property (p_drive_high_at)
    else $error("weak driver went high at the wrong count");

  property p_hold_time;
    $fell(reset_reg) |-> $past(hold_cnt_reg) == HOLD_LAST
      && $past(state_reg) == SWR_ST_HOLD;
  endproperty
  a_hold_time: assert property (p_hold_time)
    else $error("reset released before the hold time");

  property p_cause_resets;
    cause |=> reset_reg ##1 reset_reg;
  endproperty
  a_cause_resets: assert property (p_cause_resets)
    else $error("reset not asserted while a cause is present");

  property p_mr_resets;
    !mr_level |=> state_reg == SWR_ST_CAUSE && !reset_n_reg;
  endproperty
  a_mr_resets: assert property (p_mr_resets)
    else $error("manual reset did not hold reset");

  property p_polarity;
    o_reset == !o_reset_n;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("reset outputs disagree");

  c_expire: cover property (wdt_expire);
  c_kick_clear: cover property (kick_edge && !reset_reg);
  c_manual: cover property ($fell(mr_level));
  c_release: cover property ($fell(reset_reg));

endmodule : swr_supervisor

// ---- verilog/swr_consts.svh ----
// timing constants of the supervisor watchdog and reset-timing block
// assumes a single free-running oscillator clock at SWR_CLK_HZ
`ifndef SWR_CONSTS_SVH
`define SWR_CONSTS_SVH

// ----------------------------------------------------------------------
// oscillator
// ----------------------------------------------------------------------
`define SWR_CLK_HZ              25000000
`define SWR_CYC_PER_MS          (`SWR_CLK_HZ / 1000)

// ----------------------------------------------------------------------
// periods, in their own unit, then in cycles
// ----------------------------------------------------------------------
`define SWR_WDOG_TIMEOUT_MS     1600
`define SWR_WDOG_CYCLES         (`SWR_WDOG_TIMEOUT_MS * `SWR_CYC_PER_MS)
// least time: SWR_CYC_PER_MS is exact at SWR_CLK_HZ, so cycles never round down
`define SWR_RESET_HOLD_MS       140
`define SWR_RESET_HOLD_CYCLES   (`SWR_RESET_HOLD_MS * `SWR_CYC_PER_MS)
`define SWR_MR_DEBOUNCE_MS      2
`define SWR_MR_DEBOUNCE_CYCLES  (`SWR_MR_DEBOUNCE_MS * `SWR_CYC_PER_MS)

// ----------------------------------------------------------------------
// internal kick driver: low for 7/8 of the period, high for the last 1/8
// ----------------------------------------------------------------------
`define SWR_KICK_LOW_NUM        7
`define SWR_KICK_LOW_DEN        8

// ----------------------------------------------------------------------
// reset levels of the input conditioners
// ----------------------------------------------------------------------
`define SWR_KICK_RESET_LEVEL    1'b0
`define SWR_MR_RESET_LEVEL      1'b1

`endif

// ---- verilog/swr_pkg.sv ----
// types shared by the supervisor watchdog and reset-timing block
// assumes nothing beyond a SystemVerilog compiler
package swr_pkg;

  // ----------------------------------------------------------------------
  // reset sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SWR_ST_CAUSE = 3'h1,  // a reset cause is present
    SWR_ST_HOLD  = 3'h2,  // causes gone, reset held for the hold time
    SWR_ST_RUN   = 3'h4   // reset released, watchdog counting
  } swr_state_type;

endpackage : swr_pkg

// ---- verilog/swr_sync_filter.sv ----
// two-flop synchroniser followed by a stability filter
// assumes one clock; the level changes only after the input is stable
module swr_sync_filter
  import swr_pkg::*;
#(
  parameter int   FILTER_CYCLES = 1,
  parameter logic INIT_LEVEL    = 1'b0
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // raw and cleaned level
  input  wire logic i_raw,
  output logic      o_level
);

  localparam int CW = (FILTER_CYCLES > 1) ? $clog2(FILTER_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES - 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic          level_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          differs;
  logic          settled;

  // a differing sample only counts while it keeps differing
  assign differs  = sync2_reg != level_reg;
  assign settled  = differs && (cnt_reg == LAST);
  assign cnt_next = (differs && !settled) ? cnt_reg + 1'b1 : '0;
  assign o_level  = level_reg;

  // first flop feeds only the second
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= INIT_LEVEL;
      sync2_reg <= INIT_LEVEL;
    end else begin
      sync1_reg <= i_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // filter: bounce shorter than the window never reaches the level
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      level_reg <= INIT_LEVEL;
      cnt_reg   <= '0;
    end else begin
      cnt_reg <= cnt_next;
      if (settled) begin
        level_reg <= sync2_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  property p_filter_stable;
    $changed(level_reg) |-> $past(cnt_reg) == LAST && $past(differs);
  endproperty
  a_filter_stable: assert property (p_filter_stable)
    else $error("level changed before input was stable");

endmodule : swr_sync_filter

// ---- bench/swr_host_model.sv ----
// host-side model of the watchdog kick pin and its resolution
// assumes the bench decides when the host drives and when it lets go
module swr_host_model
  import swr_pkg::*;
(
  // clock
  input  wire logic i_clk_sys,
  // host driver
  input  wire logic i_drive_en,
  input  wire logic i_drive_val,
  // weak internal driver of the device
  input  wire logic i_weak_out,
  input  wire logic i_weak_oe,
  // resolved pin level
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last_reg = 1'b0;

  // host wins over the weak driver; an undriven pin drifts away from
  // its last level so a stale value never passes for a drive
  assign o_pin = i_drive_en ? i_drive_val
               : (i_weak_oe ? i_weak_out : ~last_reg);

  // remember the last resolved level
  always @(posedge i_clk_sys) begin
    last_reg <= o_pin;
  end
endmodule : swr_host_model

// ---- bench/tb_top.sv ----
// self-checking bench for the supervisor watchdog and reset sequencer
// assumes short counts set here and the host model on the kick pin
module tb_top
  import swr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // short counts keep the run brief
  // ----------------------------------------------------------------------
  localparam int WDOG  = 64;
  localparam int HOLD  = 20;
  localparam int DEBNC = 4;

  logic clk, resetn, sup1, sup2, mon, mr_n, drv_en, drv_val, pin;
  logic kick_out, kick_oe, rst_n, rst;
  int   n_mismatch, samples_checked, pol_bad;

  // ----------------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------------
  swr_supervisor #(.WDOG_CYCLES(WDOG), .HOLD_CYCLES(HOLD),
    .DEBNC_CYCLES(DEBNC)) u_dut (
    .i_clk_sys(clk), .i_resetn(resetn), .i_supply_ok(sup1),
    .i_supply2_ok(sup2), .i_adjustable_monitor_input(mon),
    .i_manual_reset_n(mr_n), .i_watchdog_kick_input(pin),
    .o_watchdog_kick_out(kick_out), .o_watchdog_kick_oe(kick_oe),
    .o_reset_n(rst_n), .o_reset(rst));
  swr_host_model u_host (.i_clk_sys(clk), .i_drive_en(drv_en),
    .i_drive_val(drv_val), .i_weak_out(kick_out), .i_weak_oe(kick_oe),
    .o_pin(pin));

  // 25 MHz oscillator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // both polarities must always agree once out of reset
  always @(negedge clk) begin
    if (resetn === 1'b1 && rst !== ~rst_n) pol_bad++;
  end

  // expected cycles from release to the weak driver going high
  function automatic int kick_high_at(input int wdog);
    return wdog / 8 * 7;
  endfunction : kick_high_at

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic ok, input logic [31:0] got, exp);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // cycles until reset (sel 0) or the weak driver (sel 1) reaches lvl
  task automatic wait_sig(input int sel, input logic lvl, input int bound,
                          output int n);
    n = 0;
    while ((sel ? kick_out : rst) !== lvl && n < bound) begin
      @(negedge clk);
      n++;
    end
    if ((sel ? kick_out : rst) !== lvl) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, !lvl, lvl);
      tally_and_finish();
    end
  endtask : wait_sig

  // cycles with reset asserted during a quiet stretch
  task automatic run_idle(input int cycles, output int hits);
    hits = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (rst !== 1'b0) hits++;
    end
  endtask : run_idle

  task automatic cause(input int which, input logic lvl);
    @(posedge clk);
    case (which)
      0: sup1 <= lvl;
      1: sup2 <= lvl;
      2: mon  <= lvl;
      default: mr_n <= lvl;
    endcase
  endtask : cause

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n, n1, hits, seed, len;
    n_mismatch = 0;
    samples_checked = 0;
    pol_bad = 0;
    resetn = 1'b0;
    {sup1, sup2, mon, mr_n} = 4'hF;
    drv_en = 1'b0;  // host lets the pin float from the start
    drv_val = 1'b0;
    seed = $urandom(32'h6861);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // power-up: reset held for the hold time, then released
    wait_sig(0, 1'b0, HOLD + DEBNC + 12, n);
    check(n >= HOLD, n, HOLD);
    check(kick_oe === 1'b1, kick_oe, 1);
    // floating pin: the weak driver keeps the watchdog serviced
    run_idle(8 * WDOG, hits);
    check(hits == 0, hits, 0);
    // every cause: prompt assertion, full hold after it ends
    for (int w = 0; w < 4; w++) begin
      len = (w == 3) ? DEBNC + 8 : 1 + $urandom_range(7);
      cause(w, 1'b0);
      wait_sig(0, 1'b1, DEBNC + 6, n);
      check(n <= (w == 3 ? DEBNC + 5 : 3), n,
            (w == 3 ? DEBNC + 5 : 3));
      repeat (len) @(posedge clk);
      cause(w, 1'b1);
      wait_sig(0, 1'b0, HOLD + DEBNC + 12, n);
      check(n >= HOLD && n <= HOLD + (w == 3 ? DEBNC + 6 : 3),
            n, HOLD);
    end
    // switch bounce: short low glitches give no reset, watched after each glitch and at the end
    hits = 0;
    repeat (5) begin
      cause(3, 1'b0);
      repeat ($urandom_range(1)) @(posedge clk);
      cause(3, 1'b1);
      run_idle(4, n);
      hits += n;
    end
    run_idle(12, n);
    hits += n;
    check(hits == 0, hits, 0);
    // host services: level moves and one-cycle pulses, random gaps
    @(posedge clk);
    drv_val <= pin;
    drv_en  <= 1'b1;
    hits = 0;
    for (int k = 0; k < 12; k++) begin
      run_idle(10 + $urandom_range(kick_high_at(WDOG) - 20), n);
      hits += n;
      @(posedge clk);
      drv_val <= ~drv_val;
      if (k[0]) begin
        @(posedge clk);
        drv_val <= ~drv_val;
      end
    end
    check(hits == 0, hits, 0);
    // stuck host: timer frozen through reset, counts from release
    cause(0, 1'b0);
    repeat (WDOG + 5) @(posedge clk);
    cause(0, 1'b1);
    for (int r = 0; r < 2; r++) begin
      wait_sig(0, 1'b0, HOLD + 6, n);
      check(n >= HOLD - 1 && n <= HOLD + 3, n, HOLD);
      wait_sig(1, 1'b1, WDOG + 4, n1);
      check(n1 >= kick_high_at(WDOG) - 2 && n1 <= kick_high_at(WDOG) + 2,
            n1, kick_high_at(WDOG));
      wait_sig(0, 1'b1, WDOG + 4, n);
      check(n + n1 >= WDOG - 2 && n + n1 <= WDOG + 3,
            n + n1, WDOG);
    end
    wait_sig(0, 1'b0, HOLD + 6, n);
    check(pol_bad == 0, pol_bad, 0);
    tally_and_finish();
  end
endmodule : tb_top
